// *** logic/breaker_failure_scheme.v ***
`timescale 1ns/1ns
`include "breaker_failure_defs.vh"

module breaker_failure_scheme #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter CUR_W = `CUR_W,
  parameter DLY_W = `DLY_W
) (
  input wire clock,
  input wire reset_n,
  input wire failure_scheme_enable,
  input wire pole_operating_mode,
  input wire [`SRC_W-1:0] current_source_select,
  input wire current_supervised_initiate_en,
  input wire initiate_latch_en,
  input wire three_pole_initiate_in,
  input wire [`NUM_POLE-1:0] pole_initiate_in,
  input wire scheme_inhibit_in,
  input wire [CUR_W-1:0] phase_supervision_threshold,
  input wire [CUR_W-1:0] neutral_supervision_threshold,
  input wire early_path_en,
  input wire [DLY_W-1:0] early_path_delay,
  input wire main_path_en,
  input wire [DLY_W-1:0] main_path_delay,
  input wire slow_path_en,
  input wire [DLY_W-1:0] slow_path_delay,
  input wire [`NUM_POLE-1:0] fast_aux_contact_in,
  input wire [`NUM_POLE-1:0] normal_aux_contact_in,
  input wire out_of_service_switch_in,
  input wire [CUR_W-1:0] phase_high_threshold,
  input wire [CUR_W-1:0] neutral_high_threshold,
  input wire [CUR_W-1:0] phase_low_threshold,
  input wire [CUR_W-1:0] neutral_low_threshold,
  input wire [DLY_W-1:0] low_detector_switch_delay,
  input wire [DLY_W-1:0] trip_hold_time,
  input wire [`NUM_SRC*`NUM_POLE*CUR_W-1:0] phase_current_in,
  input wire [`NUM_SRC*CUR_W-1:0] neutral_current_in,
  output reg initiated_out,
  output reg [`NUM_POLE-1:0] retrip_out,
  output reg early_path_op_out,
  output reg main_path_op_out,
  output reg slow_path_op_out,
  output reg zone_trip_out,
  output reg failed_target_out,
  output reg trip_indicator_out,
  output reg [`NUM_POLE-1:0] phase_indicator_out
);

  // operands arrive from other logic asynchronously: two flops each
  // only the second rank is ever read, so a metastable first rank never
  // reaches the decision logic; one spare bit keeps the packing regular
  localparam SYNC_W = 2 * `NUM_POLE + 4 + `NUM_POLE;
  wire [SYNC_W-1:0] raw_in;
  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;
  assign raw_in = {pole_initiate_in, fast_aux_contact_in,
                   three_pole_initiate_in, scheme_inhibit_in,
                   out_of_service_switch_in, 1'b0, normal_aux_contact_in};

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire [`NUM_POLE-1:0] pole_init_s = sync2_q[SYNC_W-1 -: `NUM_POLE];
  wire [`NUM_POLE-1:0] fast_aux_s = sync2_q[SYNC_W-4 -: `NUM_POLE];
  wire three_init_s = sync2_q[`NUM_POLE+3];
  wire inhibit_s = sync2_q[`NUM_POLE+2];
  wire oos_s = sync2_q[`NUM_POLE+1];
  wire [`NUM_POLE-1:0] norm_aux_s = sync2_q[`NUM_POLE-1:0];

  // protection pass tick divider
  // one pulse per millisecond paces every timer of the scheme; the divider
  // runs free, so a timer may see its first tick anywhere in that window
  reg [`TICK_W-1:0] tick_cnt_q;
  reg tick_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= {`TICK_W{1'b0}};
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[`TICK_W-1:0] - 1'b1) begin
      tick_cnt_q <= {`TICK_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // source selection for phase and neutral magnitudes
  // the two-bit select covers exactly the four sources, so it needs no guard
  wire [`NUM_POLE*CUR_W-1:0] ph_sel =
    phase_current_in[current_source_select*`NUM_POLE*CUR_W +:
                     `NUM_POLE*CUR_W];
  wire [CUR_W-1:0] n_sel = neutral_current_in[current_source_select*CUR_W +:
                                              CUR_W];

  // comparison against a phase or neutral level, neutral only in 3-pole
  function above;
    input [CUR_W-1:0] cur;
    input [CUR_W-1:0] thr;
    begin
      above = (cur > thr);
    end
  endfunction

  // pickup settings outside the legal range are pulled to its ends, so a
  // zero setting cannot make an idle detector look picked up and a
  // corrupted word cannot park a detector above any real current
  function [CUR_W-1:0] clamp_thr;
    input [CUR_W-1:0] thr;
    begin
      if (thr < `THR_MIN) begin
        clamp_thr = `THR_MIN;
      end else if (thr > `THR_MAX) begin
        clamp_thr = `THR_MAX;
      end else begin
        clamp_thr = thr;
      end
    end
  endfunction

  // timers stop at full scale instead of wrapping back to zero
  function at_max;
    input [DLY_W-1:0] t;
    begin
      at_max = (t == {DLY_W{1'b1}});
    end
  endfunction

  // a timer has expired once it reaches its set delay; zero expires at once
  function expired;
    input [DLY_W-1:0] t;
    input [DLY_W-1:0] d;
    begin
      expired = (t >= d);
    end
  endfunction

  // every detector compares against a clamped copy of its setting
  wire [CUR_W-1:0] ph_sup_thr;
  wire [CUR_W-1:0] ph_hi_thr;
  wire [CUR_W-1:0] ph_lo_thr;
  wire [CUR_W-1:0] n_sup_thr;
  wire [CUR_W-1:0] n_hi_thr;
  wire [CUR_W-1:0] n_lo_thr;
  assign ph_sup_thr = clamp_thr(phase_supervision_threshold);
  assign ph_hi_thr = clamp_thr(phase_high_threshold);
  assign ph_lo_thr = clamp_thr(phase_low_threshold);
  assign n_sup_thr = clamp_thr(neutral_supervision_threshold);
  assign n_hi_thr = clamp_thr(neutral_high_threshold);
  assign n_lo_thr = clamp_thr(neutral_low_threshold);

  wire three_pole_mode = (pole_operating_mode == `MODE_THREE_POLE);
  wire n_sup = three_pole_mode & above(n_sel, n_sup_thr);
  wire n_hi = three_pole_mode & above(n_sel, n_hi_thr);
  wire n_lo = three_pole_mode & above(n_sel, n_lo_thr);
  // disable takes effect on the next clock, the inhibit operand two clocks
  // later through its synchroniser; only disable drops the failed target,
  // so an incomplete-sequence reset does not hide a declared failure
  wire clear_all = !failure_scheme_enable | inhibit_s;

  // per-pole segregation; in 3-pole mode every pole follows the 3-pole
  // initiate and any phase current, so the same generate serves both modes
  wire [`NUM_POLE-1:0] pole_active;
  wire [`NUM_POLE-1:0] pole_early;
  wire [`NUM_POLE-1:0] pole_main;
  wire [`NUM_POLE-1:0] pole_slow;
  wire any_ph_sup;
  wire any_ph_hi;
  wire any_ph_lo;
  wire [`NUM_POLE-1:0] ph_sup_v;
  wire [`NUM_POLE-1:0] ph_hi_v;
  wire [`NUM_POLE-1:0] ph_lo_v;
  assign any_ph_sup = |ph_sup_v;
  assign any_ph_hi = |ph_hi_v;
  assign any_ph_lo = |ph_lo_v;

  genvar p;
  generate
    for (p = 0; p < `NUM_POLE; p = p + 1) begin : pole
      wire [CUR_W-1:0] cur = ph_sel[p*CUR_W +: CUR_W];
      assign ph_sup_v[p] = above(cur, ph_sup_thr);
      assign ph_hi_v[p] = above(cur, ph_hi_thr);
      assign ph_lo_v[p] = above(cur, ph_lo_thr);
      // supervision, high and low levels seen by this pole
      wire sup = three_pole_mode ? (any_ph_sup | n_sup) : ph_sup_v[p];
      wire hi = three_pole_mode ? (any_ph_hi | n_hi) : ph_hi_v[p];
      wire lo = three_pole_mode ? (any_ph_lo | n_lo) : ph_lo_v[p];
      wire init_raw = three_pole_mode ? three_init_s :
                      (pole_init_s[p] | three_init_s);
      wire fast_aux = three_pole_mode ? fast_aux_s[0] : fast_aux_s[p];
      wire norm_aux = three_pole_mode ? norm_aux_s[0] : norm_aux_s[p];
      reg latch_q;
      reg [DLY_W-1:0] t_q;
      reg [DLY_W-1:0] lo_t_q;
      // a supervised initiate is refused for a breaker carrying little
      // current; low-level faults then rely on supervision being off
      wire accept = init_raw & (!current_supervised_initiate_en | sup);
      // seal-in holds only while current stays above supervision
      wire act = accept | (latch_q & initiate_latch_en & sup);
      assign pole_active[p] = act;
      // each path shares the one initiation timer and compares its own delay
      wire t1_done = act & expired(t_q, early_path_delay);
      wire t2_done = act & expired(t_q, main_path_delay);
      wire t3_done = act & expired(t_q, slow_path_delay);
      // past the delay use high level, past the switch delay the low one
      wire lo_sel = expired(lo_t_q, low_detector_switch_delay);
      wire cur_det = lo_sel ? lo : hi;
      assign pole_early[p] = early_path_en & t1_done & fast_aux &
                             cur_det;
      assign pole_main[p] = main_path_en & t2_done & cur_det;
      assign pole_slow[p] = slow_path_en & t3_done & norm_aux &
                            !oos_s;
      // seal-in follows every clock, so an initiate shorter than one
      // protection pass is still caught and held while current flows
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          latch_q <= 1'b0;
        end else if (clear_all) begin
          latch_q <= 1'b0;
        end else begin
          latch_q <= act;
        end
      end

      // timers only advance on the protection tick and saturate at max
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          t_q <= `DLY_DEFAULT;
          lo_t_q <= `DLY_DEFAULT;
        end else if (clear_all) begin
          t_q <= `DLY_DEFAULT;
          lo_t_q <= `DLY_DEFAULT;
        end else if (tick_q) begin
          if (!act) begin
            t_q <= `DLY_DEFAULT;
          end else if (!at_max(t_q)) begin
            t_q <= t_q + 1'b1;
          end
          // low-switch timer starts once either current path timed out
          if (!(t1_done | t2_done)) begin
            lo_t_q <= `DLY_DEFAULT;
          end else if (!at_max(lo_t_q)) begin
            lo_t_q <= lo_t_q + 1'b1;
          end
        end
      end
    end
  endgenerate

  // trip hold: failure seals the trip in for trip_hold_time ticks
  // the hold reloads on every failing pass, so it is measured from the
  // last pass that still saw a failed breaker, not from the first one
  wire fail_now = |(pole_early | pole_main | pole_slow);
  reg [DLY_W-1:0] hold_q;
  reg holding_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= `DLY_DEFAULT;
      holding_q <= 1'b0;
    end else if (clear_all) begin
      hold_q <= `DLY_DEFAULT;
      holding_q <= 1'b0;
    end else if (tick_q) begin
      if (fail_now) begin
        hold_q <= trip_hold_time;
        holding_q <= 1'b1;
      end else if (hold_q != `DLY_DEFAULT) begin
        hold_q <= hold_q - 1'b1;
      end else begin
        holding_q <= 1'b0;
      end
    end
  end

  // outputs registered; path, trip and indicator outputs updated on the tick so they follow the pass
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      initiated_out <= 1'b0;
      retrip_out <= {`NUM_POLE{1'b0}};
      early_path_op_out <= 1'b0;
      main_path_op_out <= 1'b0;
      slow_path_op_out <= 1'b0;
      zone_trip_out <= 1'b0;
      failed_target_out <= 1'b0;
      trip_indicator_out <= 1'b0;
      phase_indicator_out <= {`NUM_POLE{1'b0}};
    end else if (clear_all) begin
      initiated_out <= 1'b0;
      retrip_out <= {`NUM_POLE{1'b0}};
      early_path_op_out <= 1'b0;
      main_path_op_out <= 1'b0;
      slow_path_op_out <= 1'b0;
      zone_trip_out <= 1'b0;
      trip_indicator_out <= 1'b0;
      phase_indicator_out <= {`NUM_POLE{1'b0}};
      failed_target_out <= failed_target_out & failure_scheme_enable;
    end else begin
      // re-trip follows acceptance without waiting for a tick
      initiated_out <= |pole_active;
      retrip_out <= pole_active;
      if (tick_q) begin
        early_path_op_out <= |pole_early;
        main_path_op_out <= |pole_main;
        slow_path_op_out <= |pole_slow;
        zone_trip_out <= fail_now | (holding_q & hold_q != `DLY_DEFAULT);
        trip_indicator_out <= fail_now | trip_indicator_out;
        // target stays latched like a front-panel message until disabled
        failed_target_out <= fail_now | failed_target_out;
        // only single-pole operation names a phase; a three-pole failure
        // lights the trip indicator alone
        if (fail_now && !three_pole_mode) begin
          phase_indicator_out <= phase_indicator_out | pole_active;
        end
      end
    end
  end

endmodule

// *** shared/breaker_failure_defs.vh ***
`ifndef BREAKER_FAILURE_DEFS_VH
`define BREAKER_FAILURE_DEFS_VH
// current magnitudes and thresholds in units of 0.001 pu
`define CUR_W 15
`define THR_DEFAULT 15'h041a
`define THR_MIN 15'h0001
`define THR_MAX 15'h7530
// delays in milliseconds, 0.000 s to 65.535 s
`define DLY_W 16
`define DLY_DEFAULT 16'h0000
// protection pass tick: one evaluation per millisecond at 100 MHz
`define CLOCK_HZ 100000000
`define TICK_NS 1000000
`define TICK_CYCLES ((`CLOCK_HZ / 1000) * (`TICK_NS / 1000) / 1000)
`define TICK_W 17
// operating mode codes
`define MODE_THREE_POLE 1'b0
`define MODE_SINGLE_POLE 1'b1
`define SRC_W 2
`define SRC_DEFAULT 2'h0
`define NUM_SRC 4
`define NUM_POLE 3
`endif

// *** tb/breaker_failure_properties.sv ***
`timescale 1ns/1ns
// port-level checks of the failure scheme against its settings
module breaker_failure_properties (
  input wire clock,
  input wire reset_n,
  input wire failure_scheme_enable,
  input wire scheme_inhibit_in,
  input wire three_pole_initiate_in,
  input wire current_supervised_initiate_en,
  input wire early_path_en,
  input wire main_path_en,
  input wire slow_path_en,
  input wire [2:0] fast_aux_contact_in,
  input wire out_of_service_switch_in,
  input wire [2:0] retrip_out,
  input wire early_path_op_out,
  input wire main_path_op_out,
  input wire slow_path_op_out,
  input wire zone_trip_out,
  input wire failed_target_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // inhibit and initiate pass two sync flops and an output flop, so five cycles leave a margin of one; the enable is not synchronised and clears sooner
  a_disable_clears: assert property (
    !failure_scheme_enable [*5] |-> !zone_trip_out && retrip_out == 3'h0)
    else $error("output active while disabled");
  a_inhibit_clears: assert property (
    scheme_inhibit_in [*5] |-> !zone_trip_out && retrip_out == 3'h0)
    else $error("output active while inhibited");
  a_retrip_follows: assert property (
    (three_pole_initiate_in && failure_scheme_enable && !scheme_inhibit_in
    && !current_supervised_initiate_en) [*5] |-> retrip_out != 3'h0)
    else $error("retrip missing after initiate");
  // a path output may only rise when its qualifiers allow it
  a_early_gate: assert property (
    (!early_path_en || fast_aux_contact_in == 3'h0) [*5]
    |-> !$rose(early_path_op_out)) else $error("early path rose");
  a_main_gate: assert property (
    !main_path_en [*5] |-> !$rose(main_path_op_out))
    else $error("main path rose while off");
  a_slow_gate: assert property (
    (!slow_path_en || out_of_service_switch_in) [*5]
    |-> !$rose(slow_path_op_out)) else $error("slow path rose");
  a_trip_cause: assert property (
    $rose(zone_trip_out) |-> early_path_op_out || main_path_op_out
    || slow_path_op_out) else $error("zone trip without a path");
  a_target_sticky: assert property (
    failed_target_out && failure_scheme_enable && !scheme_inhibit_in
    |=> failed_target_out) else $error("target dropped");
  c_early: cover property ($rose(early_path_op_out));
  c_slow: cover property ($rose(slow_path_op_out));
  c_hold_end: cover property ($fell(zone_trip_out));
endmodule
bind breaker_failure_scheme breaker_failure_properties u_props (.*);

// *** tb/breaker_model.sv ***
`timescale 1ns/1ns
// breaker that parts its contacts some cycles after a trip command
module breaker_model #(
  parameter OPEN_CYCLES = 15
) (
  input wire clock,
  input wire reset_n,
  input wire trip_cmd,
  input wire close_cmd,
  input wire [1:0] stuck_mode,
  input wire [14:0] fault_level,
  output reg [2:0] aux_q,
  output reg [14:0] current_q
);
  reg [7:0] count_q;
  // mode 1 never moves; mode 2 opens but the arc keeps current flowing
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
      aux_q <= 3'h0;
      current_q <= 15'h0000;
    end else if (close_cmd) begin
      count_q <= 8'h00;
      aux_q <= 3'h7;
      current_q <= fault_level;
    end else if (trip_cmd && count_q != OPEN_CYCLES) begin
      count_q <= count_q + 8'h01;
    end else if (trip_cmd) begin
      if (stuck_mode != 2'h1)
        aux_q <= 3'h0;
      if (stuck_mode == 2'h0)
        current_q <= 15'h0000;
    end
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`include "breaker_failure_defs.vh"
module tb_top;
  reg clock = 1'b0, reset_n = 1'b0, failure_scheme_enable = 1'b0;
  reg pole_operating_mode = 1'b0, initiate_latch_en = 1'b0;
  reg current_supervised_initiate_en = 1'b0, three_pole_initiate_in = 1'b0;
  reg scheme_inhibit_in = 1'b0, out_of_service_switch_in = 1'b0;
  reg early_path_en = 1'b1, main_path_en = 1'b1, slow_path_en = 1'b1;
  reg [1:0] current_source_select = 2'h2, stuck = 2'h0;
  reg [2:0] pole_initiate_in = 3'h0;
  reg close_cmd = 1'b0;
  reg pulse_init = 1'b0, phase_on = 1'b1, neutral_on = 1'b0;
  reg [14:0] level = 15'h07d0, phase_supervision_threshold = `THR_DEFAULT;
  reg [14:0] neutral_supervision_threshold = `THR_DEFAULT;
  reg [14:0] phase_high_threshold = `THR_DEFAULT;
  reg [14:0] neutral_high_threshold = `THR_DEFAULT;
  reg [14:0] phase_low_threshold = 15'h01f4, neutral_low_threshold = 15'h01f4;
  reg [15:0] early_path_delay = 16'h0003, main_path_delay = 16'h0005;
  reg [15:0] slow_path_delay = 16'h0008, low_detector_switch_delay = 16'h0002;
  reg [15:0] trip_hold_time = 16'h0004;
  wire [2:0] retrip_out, phase_indicator_out, fast_aux_contact_in;
  wire [2:0] normal_aux_contact_in;
  wire initiated_out, early_path_op_out, main_path_op_out, slow_path_op_out;
  wire zone_trip_out, failed_target_out, trip_indicator_out;
  wire [14:0] cur;
  integer errors = 0, checked = 0, cycles = 0;
  // fault current flows on source 2 only; neutral stays quiet until neutral_on is set
  wire [14:0] ph_cur = phase_on ? cur : 15'h0000;
  wire [14:0] n_cur = neutral_on ? cur : 15'h0000;
  wire [179:0] phase_current_in = {45'h0, ph_cur, ph_cur, ph_cur, 90'h0};
  wire [59:0] neutral_current_in = {15'h0000, n_cur, 30'h0};
  wire trip_cmd = |retrip_out | zone_trip_out;
  assign normal_aux_contact_in = fast_aux_contact_in;
  breaker_failure_scheme #(.TICK_CYCLES(10)) u_breaker_failure_scheme (.*);
  breaker_model u_breaker_model (.clock(clock), .reset_n(reset_n),
    .trip_cmd(trip_cmd), .close_cmd(close_cmd), .stuck_mode(stuck),
    .fault_level(level), .aux_q(fast_aux_contact_in), .current_q(cur));
  always #5 clock = ~clock;
  // stimulus moves 1 ns after the edge so the design samples it cleanly
  task cyc(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input string name, input [2:0] seen, input [2:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // clear by disabling, close the breaker, initiate, judge 25 ms later
  task run(input [1:0] m, input o, input [2:0] pe, input r, input [2:0] x);
    failure_scheme_enable = 1'b0;
    three_pole_initiate_in = 1'b0;
    pole_initiate_in = 3'h0;
    close_cmd = 1'b1;
    stuck = m;
    out_of_service_switch_in = o;
    {early_path_en, main_path_en, slow_path_en} = pe;
    cyc(5);
    chk("clear", {zone_trip_out, failed_target_out, |retrip_out}, 0);
    failure_scheme_enable = 1'b1;
    close_cmd = 1'b0;
    cyc(3);
    three_pole_initiate_in = !pole_operating_mode;
    pole_initiate_in = {1'b0, pole_operating_mode, 1'b0};
    cyc(4);
    chk("retrip", {1'b0, initiated_out, |retrip_out}, {1'b0, r, r});
    if (pulse_init) begin
      three_pole_initiate_in = 1'b0;
      pole_initiate_in = 3'h0;
    end
    cyc(250);
    chk("paths", {early_path_op_out, main_path_op_out, slow_path_op_out},
      x);
    chk("trip", {zone_trip_out, failed_target_out, trip_indicator_out},
      {3{|x}});
  endtask
  // the ceiling sits well above the roughly 4550 cycles of the tests
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  initial begin
    cyc(4);
    reset_n = 1'b1;
    three_pole_initiate_in = 1'b1;
    cyc(10);
    chk("disabled", {2'h0, |retrip_out}, 3'h0);
    run(2'h0, 1'b0, 3'h7, 1'b1, 3'h0);
    run(2'h2, 1'b0, 3'h7, 1'b1, 3'h2);
    run(2'h1, 1'b1, 3'h7, 1'b1, 3'h6);
    run(2'h1, 1'b0, 3'h3, 1'b1, 3'h3);
    run(2'h1, 1'b0, 3'h0, 1'b1, 3'h0);
    run(2'h1, 1'b0, 3'h7, 1'b1, 3'h7);
    scheme_inhibit_in = 1'b1;
    cyc(5);
    chk("inhibit", {zone_trip_out, |retrip_out, 1'b0}, 3'h0);
    scheme_inhibit_in = 1'b0;
    cyc(250);
    stuck = 2'h0;
    cyc(25);
    chk("hold", {2'h0, zone_trip_out}, 3'h1);
    cyc(60);
    chk("drop", {2'h0, zone_trip_out}, 3'h0);
    current_supervised_initiate_en = 1'b1;
    level = `THR_DEFAULT;
    run(2'h0, 1'b0, 3'h7, 1'b0, 3'h0);
    level = 15'h07d0;
    current_source_select = 2'h0;
    run(2'h0, 1'b0, 3'h7, 1'b0, 3'h0);
    current_source_select = 2'h2;
    run(2'h0, 1'b0, 3'h7, 1'b1, 3'h0);
    current_supervised_initiate_en = 1'b0;
    initiate_latch_en = 1'b1;
    pulse_init = 1'b1;
    run(2'h1, 1'b0, 3'h7, 1'b1, 3'h7);
    run(2'h0, 1'b0, 3'h7, 1'b1, 3'h0);
    chk("release", {2'h0, |retrip_out}, 3'h0);
    initiate_latch_en = 1'b0;
    run(2'h1, 1'b0, 3'h7, 1'b1, 3'h0);
    pulse_init = 1'b0;
    phase_low_threshold = 15'h0bb8;
    run(2'h2, 1'b0, 3'h7, 1'b1, 3'h0);
    phase_low_threshold = 15'h01f4;
    pole_operating_mode = 1'b1;
    run(2'h1, 1'b0, 3'h7, 1'b1, 3'h7);
    chk("poles", retrip_out, 3'h2);
    chk("phase led", phase_indicator_out, 3'h2);
    phase_on = 1'b0;
    neutral_on = 1'b1;
    run(2'h2, 1'b0, 3'h7, 1'b1, 3'h0);
    pole_operating_mode = 1'b0;
    run(2'h2, 1'b0, 3'h7, 1'b1, 3'h2);
    print_verdict;
  end
endmodule
